// *** hw/rid_core.sv ***
// Operation
// - or/xor acc with file, zero only
// - decrement file, skip when zero
// - increment file, skip when zero, flags kept
// - rotate left through carry, carry only
// - rotate right through carry, carry only
// - test bit, skip when low
// - test bit, skip when high
// - literal or/xor/and, zero only
// - literal minus acc, literal plus acc
// - returns take two cycles
// - sleep and watchdog kick set status
// - io read-modify-write uses pin levels
// - timer register write clears prescaler, except the OPC_MISC move from acc
// - branch or true test costs two cycles
// - destination bit picks acc or file
// - four clocks per instruction cycle
// - seven-bit register address
`timescale 1ns/1ps
`default_nettype none
module rid_core import rid_pkg::*; (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [13:0] instr,
  input wire logic [7:0] file_rdata,
  input wire logic file_is_io,
  input wire logic [7:0] pin_rdata,
  input wire logic presc_on_timer,
  output logic instr_taken,
  output logic [6:0] file_addr,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic [7:0] acc,
  output rid_status_t status,
  output logic presc_clr,
  output rid_pc_op_t pc_op,
  output logic [10:0] pc_target,
  output logic skip,
  output logic cycle_end
);
  rid_state_t s;
  rid_state_t next_s;

  // ****************************************************************
  // decode of the held instruction
  // ****************************************************************
  logic [1:0] cls;
  logic [3:0] opc;
  rid_alu_op_t aop;
  logic to_acc, to_file, fz, fcdc, fc, skz, tstl, tsth;
  logic kick, nap, no_presc;
  rid_pc_op_t pcop;
  logic [7:0] opnd, alu_b, res;
  logic alu_c, alu_dc, bitv, exec, take_skip;
  logic [13:0] fetched;

  assign cls = s.ir[CLS_HI:CLS_LO];
  assign opc = s.ir[OP_HI:OP_LO];
  // pins, not the output latch, feed io read-modify-write
  assign opnd = file_is_io ? pin_rdata : file_rdata;
  assign alu_b = (cls == CLS_LIT) ? s.ir[K8_HI:0] : opnd;
  assign bitv = opnd[s.ir[BIT_HI:BIT_LO]];
  assign exec = (s.phase == PH_EXEC);
  assign fetched = s.flush ? W_NOP : instr;

  always_comb begin
    aop = ALU_PASSA;
    to_acc = 1'b0;
    to_file = 1'b0;
    fz = 1'b0;
    fcdc = 1'b0;
    fc = 1'b0;
    skz = 1'b0;
    tstl = 1'b0;
    tsth = 1'b0;
    kick = 1'b0;
    nap = 1'b0;
    no_presc = 1'b0;
    pcop = PC_STEP;
    case (cls)
      CLS_BYTE: begin
        to_file = s.ir[DEST_BIT];
        to_acc = !s.ir[DEST_BIT];
        case (opc)
          OPC_ADD: begin
            aop = ALU_ADD;
            fz = 1'b1;
            fcdc = 1'b1;
          end
          OPC_SUB: begin
            aop = ALU_SUB;
            fz = 1'b1;
            fcdc = 1'b1;
          end
          OPC_AND: begin
            aop = ALU_AND;
            fz = 1'b1;
          end
          OPC_IOR: begin
            aop = ALU_OR;
            fz = 1'b1;
          end
          OPC_XOR: begin
            aop = ALU_XOR;
            fz = 1'b1;
          end
          OPC_CLR: begin
            aop = ALU_ZERO;
            fz = 1'b1;
          end
          OPC_COM: begin
            aop = ALU_COM;
            fz = 1'b1;
          end
          OPC_DEC: begin
            aop = ALU_DEC;
            fz = 1'b1;
          end
          OPC_INC: begin
            aop = ALU_INC;
            fz = 1'b1;
          end
          OPC_MOV: begin
            aop = ALU_PASSB;
            fz = 1'b1;
          end
          OPC_DECSKP: begin
            aop = ALU_DEC;
            skz = 1'b1;
          end
          OPC_INCSKP: begin
            aop = ALU_INC;
            skz = 1'b1;
          end
          OPC_RLC: begin
            aop = ALU_RL;
            fc = 1'b1;
          end
          OPC_RRC: begin
            aop = ALU_RR;
            fc = 1'b1;
          end
          OPC_SWAP: aop = ALU_SWAP;
          OPC_MISC: begin
            to_acc = 1'b0;
            no_presc = 1'b1;
            if (!s.ir[DEST_BIT]) begin
              to_file = 1'b0;
              case (s.ir)
                W_RETURN: pcop = PC_RETURN;
                W_INT_EXIT: pcop = PC_INT_EXIT;
                W_KICK: kick = 1'b1;
                W_SLEEP: nap = 1'b1;
                default: pcop = PC_STEP;
              endcase
            end
          end
          default: aop = ALU_PASSA;
        endcase
      end
      CLS_BIT: begin
        case (s.ir[OP_HI:LIT_SEL_LO])
          BOP_CLR: begin
            aop = ALU_BCLR;
            to_file = 1'b1;
          end
          BOP_SET: begin
            aop = ALU_BSET;
            to_file = 1'b1;
          end
          BOP_TSTL: tstl = 1'b1;
          default: tsth = 1'b1;
        endcase
      end
      CLS_CTRL: pcop = s.ir[OP_HI] ? PC_JUMP : PC_CALL;
      default: begin
        to_acc = 1'b1;
        aop = ALU_PASSB;
        if (s.ir[OP_HI:LIT_SEL_LO] == LSEL_RET) begin
          pcop = PC_RETLIT;
        end else if (s.ir[OP_HI:LIT_SEL_LO] != LSEL_MOV) begin
          if (s.ir[OP_HI:LIT_AS_LO] == LOPC_ADD) begin
            aop = ALU_ADD;
            fz = 1'b1;
            fcdc = 1'b1;
          end else if (s.ir[OP_HI:LIT_AS_LO] == LOPC_SUB) begin
            aop = ALU_SUB;
            fz = 1'b1;
            fcdc = 1'b1;
          end else begin
            fz = 1'b1;
            case (opc)
              LOPC_IOR: aop = ALU_OR;
              LOPC_AND: aop = ALU_AND;
              LOPC_XOR: aop = ALU_XOR;
              default: aop = ALU_PASSB;
            endcase
          end
        end
      end
    endcase
  end

  rid_alu u_alu (
    .op(aop),
    .a(s.acc),
    .b(alu_b),
    .cin(s.st.c),
    .bsel(s.ir[BIT_HI:BIT_LO]),
    .res(res),
    .c(alu_c),
    .dc(alu_dc)
  );

  assign take_skip = (skz && res == BYTE_ZERO) || (tstl && !bitv) ||
                     (tsth && bitv);

  // ****************************************************************
  // sequencing: fetch on the first clock, execute on the fourth
  // ****************************************************************
  always_comb begin
    next_s = s;
    next_s.phase = s.phase + PH_STEP;
    next_s.file_we = 1'b0;
    next_s.presc_clr = 1'b0;
    next_s.pc_op = PC_STEP;
    next_s.skip = 1'b0;
    next_s.cycle_end = 1'b0;
    next_s.instr_taken = 1'b0;
    if (s.phase == PH_FETCH) begin
      // a flushed slot runs as a no-op so the pipeline stays aligned
      next_s.ir = fetched;
      next_s.flush = 1'b0;
      next_s.instr_taken = !s.flush;
      next_s.file_addr = fetched[ADDR_HI:0];
    end
    if (exec) begin
      next_s.cycle_end = 1'b1;
      if (to_acc) begin
        next_s.acc = res;
      end
      if (to_file) begin
        next_s.file_we = 1'b1;
        next_s.file_wdata = res;
      end
      if (fz) begin
        next_s.st.z = (res == BYTE_ZERO);
      end
      if (fcdc || fc) begin
        next_s.st.c = alu_c;
      end
      if (fcdc) begin
        next_s.st.dc = alu_dc;
      end
      if (kick) begin
        next_s.st.watchdog_expiry_flag = 1'b1;
        next_s.st.sleep_entered_flag = 1'b1;
      end
      if (nap) begin
        next_s.st.watchdog_expiry_flag = 1'b1;
        next_s.st.sleep_entered_flag = 1'b0;
      end
      next_s.presc_clr = to_file && !no_presc && presc_on_timer &&
                         s.file_addr == TIMER_ZERO_ADDR;
      next_s.skip = take_skip;
      next_s.pc_op = pcop;
      next_s.pc_target = s.ir[K11_HI:0];
      next_s.flush = take_skip || pcop != PC_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s <= '0;
      s.st <= STATUS_RESET;
      s.pc_op <= PC_STEP;
    end else begin
      s <= next_s;
    end
  end

  assign instr_taken = s.instr_taken;
  assign file_addr = s.file_addr;
  assign file_we = s.file_we;
  assign file_wdata = s.file_wdata;
  assign acc = s.acc;
  assign status = s.st;
  assign presc_clr = s.presc_clr;
  assign pc_op = s.pc_op;
  assign pc_target = s.pc_target;
  assign skip = s.skip;
  assign cycle_end = s.cycle_end;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence nop_slot;
    ##4 (cycle_end && !file_we && pc_op == PC_STEP && !skip);
  endsequence

  a_cycle_four_clk: assert property (
    cycle_end |=> !cycle_end [*3] ##1 cycle_end)
    else $error("instruction cycle is not four clocks");
  a_skip_nop_slot: assert property (
    (skip || pc_op != PC_STEP) |-> nop_slot)
    else $error("second cycle did not run as a no-op");
  a_dec_skip_zero: assert property (
    (exec && cls == CLS_BYTE && opc == OPC_DECSKP && res == BYTE_ZERO)
    |=> skip)
    else $error("decrement to zero did not skip");
  a_inc_flags_kept: assert property (
    (exec && cls == CLS_BYTE && opc == OPC_INCSKP) |=>
    (status == $past(status) && skip == ($past(res) == BYTE_ZERO)))
    else $error("increment-skip changed flags or skip wrong");
  a_rotl_carry: assert property (
    (exec && cls == CLS_BYTE && opc == OPC_RLC) |=>
    (status.c == $past(opnd[7]) && status.z == $past(status.z)))
    else $error("rotate left carry wrong");
  a_rotr_carry: assert property (
    (exec && cls == CLS_BYTE && opc == OPC_RRC) |=>
    (status.c == $past(opnd[0]) && status.z == $past(status.z)))
    else $error("rotate right carry wrong");
  a_test_low_skip: assert property (
    (exec && tstl) |=> (skip == !$past(bitv)))
    else $error("test-low skip wrong");
  a_test_high_skip: assert property (
    (exec && tsth) |=> (skip == $past(bitv)))
    else $error("test-high skip wrong");
  a_sleep_status: assert property (
    (exec && s.ir == W_SLEEP) |=>
    (status.watchdog_expiry_flag && !status.sleep_entered_flag))
    else $error("sleep status bits wrong");
  a_io_pin_source: assert property (
    (exec && file_is_io && cls == CLS_BYTE && opc == OPC_MOV &&
     s.ir[DEST_BIT]) |=> (file_we && file_wdata == $past(pin_rdata)))
    else $error("io write-back did not use pin levels");
  a_ior_zero_flag: assert property (
    (exec && cls == CLS_BYTE && opc == OPC_IOR) |=>
    (status.z == ((($past(s.acc) | $past(opnd))) == BYTE_ZERO) &&
     status.c == $past(status.c)))
    else $error("inclusive or zero flag wrong");
endmodule
`default_nettype wire

// *** hw/rid_pkg.sv ***
package rid_pkg;

  // ****************************************************************
  // instruction word layout
  // ****************************************************************
  localparam int INSTR_W = 14;
  localparam int CLS_HI = 13;
  localparam int CLS_LO = 12;
  localparam int OP_HI = 11;
  localparam int OP_LO = 8;
  localparam int DEST_BIT = 7;
  localparam int ADDR_HI = 6;
  localparam int BIT_HI = 9;
  localparam int BIT_LO = 7;
  localparam int K8_HI = 7;
  localparam int K11_HI = 10;
  localparam int LIT_SEL_LO = 10;
  localparam int LIT_AS_LO = 9;

  localparam logic [1:0] CLS_BYTE = 2'h0;
  localparam logic [1:0] CLS_BIT = 2'h1;
  localparam logic [1:0] CLS_CTRL = 2'h2;
  localparam logic [1:0] CLS_LIT = 2'h3;

  // byte-oriented operation codes
  localparam logic [3:0] OPC_MISC = 4'h0;
  localparam logic [3:0] OPC_CLR = 4'h1;
  localparam logic [3:0] OPC_SUB = 4'h2;
  localparam logic [3:0] OPC_DEC = 4'h3;
  localparam logic [3:0] OPC_IOR = 4'h4;
  localparam logic [3:0] OPC_AND = 4'h5;
  localparam logic [3:0] OPC_XOR = 4'h6;
  localparam logic [3:0] OPC_ADD = 4'h7;
  localparam logic [3:0] OPC_MOV = 4'h8;
  localparam logic [3:0] OPC_COM = 4'h9;
  localparam logic [3:0] OPC_INC = 4'hA;
  localparam logic [3:0] OPC_DECSKP = 4'hB;
  localparam logic [3:0] OPC_RRC = 4'hC;
  localparam logic [3:0] OPC_RLC = 4'hD;
  localparam logic [3:0] OPC_SWAP = 4'hE;
  localparam logic [3:0] OPC_INCSKP = 4'hF;

  // bit-oriented operation codes, bits 11:10
  localparam logic [1:0] BOP_CLR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_TSTL = 2'h2;
  localparam logic [1:0] BOP_TSTH = 2'h3;

  // literal operation codes
  localparam logic [1:0] LSEL_MOV = 2'h0;
  localparam logic [1:0] LSEL_RET = 2'h1;
  localparam logic [3:0] LOPC_IOR = 4'h8;
  localparam logic [3:0] LOPC_AND = 4'h9;
  localparam logic [3:0] LOPC_XOR = 4'hA;
  localparam logic [2:0] LOPC_SUB = 3'h6;
  localparam logic [2:0] LOPC_ADD = 3'h7;

  // whole-word control instructions
  localparam logic [13:0] W_NOP = 14'h0000;
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_INT_EXIT = 14'h0009;
  localparam logic [13:0] W_SLEEP = 14'h0063;
  localparam logic [13:0] W_KICK = 14'h0064;

  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONE = 8'h01;

  // ****************************************************************
  // instruction cycle timing
  // ****************************************************************
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [1:0] PH_FETCH = 2'h0;
  localparam logic [1:0] PH_EXEC = 2'(OSC_PER_CYCLE - 1);
  localparam logic [1:0] PH_STEP = 2'h1;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_COM, ALU_INC,
    ALU_DEC, ALU_RL, ALU_RR, ALU_SWAP, ALU_PASSA, ALU_PASSB,
    ALU_ZERO, ALU_BCLR, ALU_BSET
  } rid_alu_op_t;

  typedef enum logic [2:0] {
    PC_STEP, PC_CALL, PC_JUMP, PC_RETURN, PC_INT_EXIT, PC_RETLIT
  } rid_pc_op_t;

  typedef struct packed {
    logic watchdog_expiry_flag;
    logic sleep_entered_flag;
    logic z;
    logic dc;
    logic c;
  } rid_status_t;

  localparam rid_status_t STATUS_RESET = 5'h18;

  typedef struct packed {
    logic [1:0] phase;
    logic [13:0] ir;
    logic flush;
    logic [7:0] acc;
    rid_status_t st;
    logic [6:0] file_addr;
    logic file_we;
    logic [7:0] file_wdata;
    logic presc_clr;
    rid_pc_op_t pc_op;
    logic [10:0] pc_target;
    logic skip;
    logic cycle_end;
    logic instr_taken;
  } rid_state_t;

  function automatic logic [7:0] bit_mask(input logic [2:0] idx);
    bit_mask = 8'(BYTE_ONE << idx);
  endfunction

endpackage

// *** hw/rid_alu.sv ***
`timescale 1ns/1ps
`default_nettype none
module rid_alu import rid_pkg::*; (
  input wire rid_alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic cin,
  input wire logic [2:0] bsel,
  output logic [7:0] res,
  output logic c,
  output logic dc
);
  logic [8:0] sum9;
  logic [4:0] sum5;

  always_comb begin
    sum9 = 9'h000;
    sum5 = 5'h00;
    res = b;
    c = cin;
    dc = 1'b0;
    case (op)
      ALU_ADD: begin
        sum9 = {1'b0, a} + {1'b0, b};
        sum5 = {1'b0, a[3:0]} + {1'b0, b[3:0]};
        res = sum9[7:0];
        c = sum9[8];
        dc = sum5[4];
      end
      ALU_SUB: begin
        // b minus a as b + ~a + 1: carry high means no borrow
        sum9 = {1'b0, b} + {1'b0, ~a} + 9'h001;
        sum5 = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
        res = sum9[7:0];
        c = sum9[8];
        dc = sum5[4];
      end
      ALU_AND: res = a & b;
      ALU_OR: res = a | b;
      ALU_XOR: res = a ^ b;
      ALU_COM: res = ~b;
      ALU_INC: res = b + BYTE_ONE;
      ALU_DEC: res = b - BYTE_ONE;
      ALU_RL: begin
        res = {b[6:0], cin};
        c = b[7];
      end
      ALU_RR: begin
        res = {cin, b[7:1]};
        c = b[0];
      end
      ALU_SWAP: res = {b[3:0], b[7:4]};
      ALU_PASSA: res = a;
      ALU_PASSB: res = b;
      ALU_ZERO: res = BYTE_ZERO;
      ALU_BCLR: res = b & ~bit_mask(bsel);
      ALU_BSET: res = b | bit_mask(bsel);
      default: res = b;
    endcase
  end
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench import rid_pkg::*; ;

  // ****************************************************************
  // clock, design and shared state
  // ****************************************************************
  logic clk = 1'b0;
  logic reset_n;
  logic [13:0] instr;
  logic [7:0] file_rdata;
  logic file_is_io;
  logic [7:0] pin_rdata;
  logic presc_on_timer;
  logic instr_taken;
  logic [6:0] file_addr;
  logic file_we;
  logic [7:0] file_wdata;
  logic [7:0] acc;
  rid_status_t status;
  logic presc_clr;
  rid_pc_op_t pc_op;
  logic [10:0] pc_target;
  logic skip;
  logic cycle_end;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] e_acc;
  rid_status_t e_st;

  always #2 clk = ~clk;

  rid_core dut (
    .clk(clk),
    .reset_n(reset_n),
    .instr(instr),
    .file_rdata(file_rdata),
    .file_is_io(file_is_io),
    .pin_rdata(pin_rdata),
    .presc_on_timer(presc_on_timer),
    .instr_taken(instr_taken),
    .file_addr(file_addr),
    .file_we(file_we),
    .file_wdata(file_wdata),
    .acc(acc),
    .status(status),
    .presc_clr(presc_clr),
    .pc_op(pc_op),
    .pc_target(pc_target),
    .skip(skip),
    .cycle_end(cycle_end)
  );

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // entered just after an execute edge, so the next edge is a fetch edge
  task automatic step(input logic [13:0] w, input logic tk,
      input logic we, input logic [7:0] wd, input logic sk,
      input rid_pc_op_t pco, input logic pclr);
    instr = w;
    @(posedge clk);
    #1;
    chk("instr_taken", 16'(tk), 16'(instr_taken));
    chk("cycle_end early", 16'h0000, 16'(cycle_end));
    if (tk) chk("file_addr", 16'(w[6:0]), 16'(file_addr));
    repeat (3) @(posedge clk);
    #1;
    chk("cycle_end", 16'h0001, 16'(cycle_end));
    chk("file_we", 16'(we), 16'(file_we));
    if (we) chk("file_wdata", 16'(wd), 16'(file_wdata));
    chk("acc", 16'(e_acc), 16'(acc));
    chk("status", 16'(e_st), 16'(status));
    chk("skip", 16'(sk), 16'(skip));
    chk("pc_op", 16'(pco), 16'(pc_op));
    chk("presc_clr", 16'(pclr), 16'(presc_clr));
    if (tk) chk("pc_target", 16'(w[10:0]), 16'(pc_target));
  endtask

  task automatic go(input logic [13:0] w, input logic we,
      input logic [7:0] wd);
    step(w, 1'b1, we, wd, 1'b0, PC_STEP, 1'b0);
  endtask

  task automatic skp(input logic [13:0] w);
    step(w, 1'b1, 1'b0, 8'h00, 1'b1, PC_STEP, 1'b0);
  endtask

  // a move-literal word that must be ignored in a flushed slot
  task automatic nop_slot();
    step(14'h30A5, 1'b0, 1'b0, 8'h00, 1'b0, PC_STEP, 1'b0);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_literal();
    e_acc = 8'hC3;
    go(14'h30C3, 1'b0, 8'h00);
    e_acc = 8'hD7;
    go(14'h3814, 1'b0, 8'h00);
    e_acc = 8'h07;
    go(14'h390F, 1'b0, 8'h00);
    e_acc = 8'h00;
    e_st.z = 1'b1;
    go(14'h3A07, 1'b0, 8'h00);
    $display("test literal logic done");
  endtask

  task automatic arith(input logic sub, input logic x, input logic [7:0] a,
      input logic [7:0] k);
    logic [8:0] s;
    e_acc = a;
    go({6'h30, a}, 1'b0, 8'h00);
    s = sub ? {1'b0, k} - {1'b0, a} : {1'b0, k} + {1'b0, a};
    e_acc = s[7:0];
    e_st.c = sub ? (k >= a) : s[8];
    e_st.dc = sub ? (k[3:0] >= a[3:0])
                  : ({1'b0, k[3:0]} + {1'b0, a[3:0]} > 5'h0F);
    e_st.z = (s[7:0] == 8'h00);
    go({2'b11, 2'b11, ~sub, x, k}, 1'b0, 8'h00);
  endtask

  task automatic t_arith();
    arith(1'b0, 1'b0, 8'h10, 8'h15);
    arith(1'b0, 1'b1, 8'hF8, 8'h08);
    arith(1'b1, 1'b0, 8'h05, 8'h03);
    arith(1'b1, 1'b1, 8'h22, 8'h22);
    $display("test literal arithmetic done");
  endtask

  task automatic t_byte();
    e_acc = 8'h5A;
    go(14'h305A, 1'b0, 8'h00);
    file_rdata = 8'h0F;
    e_st.z = 1'b0;
    go(14'h04FF, 1'b1, 8'h5F);
    file_rdata = 8'h5A;
    e_acc = 8'h00;
    e_st.z = 1'b1;
    go(14'h0600, 1'b0, 8'h00);
    presc_on_timer = 1'b1;
    e_st.z = 1'b0;
    step(14'h0681, 1'b1, 1'b1, 8'h5A, 1'b0, PC_STEP, 1'b1);
    e_acc = 8'h5A;
    go(14'h0601, 1'b0, 8'h00);
    presc_on_timer = 1'b0;
    go(14'h0481, 1'b1, 8'h5A);
    $display("test byte logic done");
  endtask

  task automatic t_skip();
    file_rdata = 8'h01;
    step(14'h0B90, 1'b1, 1'b1, 8'h00, 1'b1, PC_STEP, 1'b0);
    nop_slot();
    e_acc = 8'h00;
    step(14'h0B10, 1'b1, 1'b0, 8'h00, 1'b1, PC_STEP, 1'b0);
    nop_slot();
    file_rdata = 8'h02;
    go(14'h0B90, 1'b1, 8'h01);
    file_rdata = 8'hFF;
    step(14'h0F90, 1'b1, 1'b1, 8'h00, 1'b1, PC_STEP, 1'b0);
    nop_slot();
    file_rdata = 8'h7F;
    go(14'h0F90, 1'b1, 8'h80);
    $display("test skip counts done");
  endtask

  task automatic rot(input logic left, input logic [7:0] f);
    file_rdata = f;
    if (left) begin
      e_acc = {f[6:0], e_st.c};
      e_st.c = f[7];
    end else begin
      e_acc = {e_st.c, f[7:1]};
      e_st.c = f[0];
    end
    go({2'b00, 3'b110, left, 1'b0, 7'h20}, 1'b0, 8'h00);
  endtask

  task automatic t_rotate();
    rot(1'b1, 8'h81);
    rot(1'b1, 8'h00);
    rot(1'b0, 8'h01);
    rot(1'b0, 8'h00);
    $display("test rotate done");
  endtask

  task automatic t_bits();
    logic [2:0] b;
    logic [7:0] m;
    for (int i = 0; i < 8; i++) begin
      b = 3'(i);
      m = 8'(8'h01 << i);
      file_rdata = 8'h00;
      go({4'b0101, b, 7'h33}, 1'b1, m);
      file_rdata = 8'hFF;
      go({4'b0100, b, 7'h33}, 1'b1, ~m);
      file_rdata = m;
      go({4'b0110, b, 7'h33}, 1'b0, 8'h00);
      skp({4'b0111, b, 7'h33});
      nop_slot();
      file_rdata = ~m;
      skp({4'b0110, b, 7'h33});
      nop_slot();
      go({4'b0111, b, 7'h33}, 1'b0, 8'h00);
    end
    $display("test bit ops done");
  endtask

  task automatic t_control();
    step(14'h22A3, 1'b1, 1'b0, 8'h00, 1'b0, PC_CALL, 1'b0);
    nop_slot();
    step(14'h2FFF, 1'b1, 1'b0, 8'h00, 1'b0, PC_JUMP, 1'b0);
    nop_slot();
    step(14'h0008, 1'b1, 1'b0, 8'h00, 1'b0, PC_RETURN, 1'b0);
    nop_slot();
    step(14'h0009, 1'b1, 1'b0, 8'h00, 1'b0, PC_INT_EXIT, 1'b0);
    nop_slot();
    e_acc = 8'h9C;
    step(14'h349C, 1'b1, 1'b0, 8'h00, 1'b0, PC_RETLIT, 1'b0);
    nop_slot();
    $display("test control done");
  endtask

  task automatic t_power();
    e_st.watchdog_expiry_flag = 1'b1;
    e_st.sleep_entered_flag = 1'b0;
    go(14'h0063, 1'b0, 8'h00);
    e_st.sleep_entered_flag = 1'b1;
    go(14'h0064, 1'b0, 8'h00);
    $display("test power done");
  endtask

  task automatic t_io();
    file_is_io = 1'b1;
    file_rdata = 8'hFF;
    pin_rdata = 8'h0F;
    e_st.z = 1'b0;
    go(14'h08A5, 1'b1, 8'h0F);
    file_is_io = 1'b0;
    go(14'h08A5, 1'b1, 8'hFF);
    presc_on_timer = 1'b1;
    file_rdata = 8'h11;
    step(14'h1781, 1'b1, 1'b1, 8'h91, 1'b0, PC_STEP, 1'b1);
    presc_on_timer = 1'b0;
    $display("test io and timer done");
  endtask

  // byte codes that the other scenarios leave out
  task automatic t_misc();
    file_rdata = 8'h0F;
    go(14'h0E85, 1'b1, 8'hF0);
    e_acc = 8'hF0;
    go(14'h0905, 1'b0, 8'h00);
    e_acc = 8'h00;
    e_st.z = 1'b1;
    go(14'h0505, 1'b0, 8'h00);
    e_acc = 8'h0F;
    e_st.z = 1'b0;
    e_st.dc = 1'b0;
    e_st.c = 1'b0;
    go(14'h0705, 1'b0, 8'h00);
    e_st.z = 1'b1;
    e_st.dc = 1'b1;
    e_st.c = 1'b1;
    go(14'h0285, 1'b1, 8'h00);
    e_acc = 8'h0E;
    e_st.z = 1'b0;
    go(14'h0305, 1'b0, 8'h00);
    go(14'h0A85, 1'b1, 8'h10);
    presc_on_timer = 1'b1;
    e_st.z = 1'b1;
    step(14'h0181, 1'b1, 1'b1, 8'h00, 1'b0, PC_STEP, 1'b1);
    e_acc = 8'h00;
    go(14'h0100, 1'b0, 8'h00);
    go(14'h0081, 1'b1, 8'h00);
    presc_on_timer = 1'b0;
    $display("test byte codes done");
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    reset_n = 1'b0;
    instr = 14'h0000;
    file_rdata = 8'h00;
    file_is_io = 1'b0;
    pin_rdata = 8'h00;
    presc_on_timer = 1'b0;
    e_acc = 8'h00;
    e_st = STATUS_RESET;
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    chk("reset acc", 16'(e_acc), 16'(acc));
    chk("reset status", 16'(e_st), 16'(status));
    chk("reset pc_op", 16'(PC_STEP), 16'(pc_op));
    $display("test reset done");
    t_literal();
    t_arith();
    t_byte();
    t_skip();
    t_rotate();
    t_bits();
    t_control();
    t_power();
    t_io();
    t_misc();
    report_and_stop();
  end

  // the whole sequence needs about 2 us; allow a wide margin
  initial begin
    #20000;
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen hang");
    report_and_stop();
  end

endmodule
`default_nettype wire
